// ### line_station.sv
// Purpose: Far station on the serial line: bit timing, receive stream, monitor
// Assumes: One bit time is four aclk cycles
// Notes:   The line carries zeros between queued patterns
`timescale 1ns/1ps
module line_station (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic txd,
  output logic      bit_tick,
  output logic      rxd
);
  logic [1:0] div_q;
  bit         bits_q[$];
  int         run_q;
  int         max_run;

  assign bit_tick = (div_q == 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // New receive bit and one sample of the transmit line per bit time
  always @(posedge aclk) begin
    if (bit_tick) begin
      rxd <= (bits_q.size() > 0) ? bits_q.pop_front() : 1'b0;
      run_q = txd ? run_q + 1 : 0;
      if (run_q > max_run) begin
        max_run = run_q;
      end
    end
  end

  initial begin
    rxd = 1'b0;
    run_q = 0;
    max_run = 0;
  end

  task send(input logic [7:0] bits);
    for (int i = 0; i < 8; i++) begin
      bits_q.push_back(bits[i]);
    end
    wait (bits_q.size() == 0);
    wait_ticks(2);
  endtask : send

  task wait_ticks(input int n);
    repeat (n) @(posedge aclk iff bit_tick);
  endtask : wait_ticks

  task clr_run;
    max_run = 0;
  endtask : clr_run
endmodule : line_station

// ### sdlc_transmit_and_loop.sv
// Purpose: Bit-oriented transmit framer with loop-station mode
// Assumes: bit_tick is a one-cycle pulse per bit time, at least 2 apart
// Notes:   Registers sit in the low byte of each word
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "sdlc_tx_regs.svh"
module sdlc_transmit_and_loop (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [7:0]  awaddr,
  input  logic        awvalid,
  output logic        awready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  input  logic        wvalid,
  output logic        wready,
  output logic [1:0]  bresp,
  output logic        bvalid,
  input  logic        bready,
  input  logic [7:0]  araddr,
  input  logic        arvalid,
  output logic        arready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  output logic        rvalid,
  input  logic        rready,
  input  logic        bit_tick,
  input  logic        rxd,
  input  logic        cts_n,
  output logic        txd,
  output logic        rts_n
);
  import sdlc_tx_pkg::*;

  logic [7:0]  mode_q, txc_q, rxc_q, flag_q, mm_q, tbuf_q;
  logic        tbuf_full_q, eom_q, brk_q, hunt_q, on_loop_q, sending_q;
  logic        rx_m_q, rx_s_q, cts_m_q, cts_s_q, rx_dly_q, txd_q, rts_n_q;
  logic [7:0]  rxh_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] shreg_q, crc_q, crc_tx, ld_word;
  logic [4:0]  cnt_q, ld_cnt;
  logic [3:0]  pos_q;
  logic [2:0]  ones_q;
  logic [4:0]  zi_q;
  logic [7:0]  st_main, st_loop;
  char_kind_e  kind_q, ld_kind;
  loop_state_e lp_q;

  // Bus write decode
  wire         wr_go   = awvalid & wvalid & ~bvalid_q;
  wire         wr_lane = wr_go & wstrb[0];
  wire         wr_cmd  = wr_lane & (awaddr == `OFS_COMMAND);
  wire         wr_mode = wr_lane & (awaddr == `OFS_MODE);
  wire         wr_txc  = wr_lane & (awaddr == `OFS_TX_CTRL);
  wire         wr_rxc  = wr_lane & (awaddr == `OFS_RX_CTRL);
  wire         wr_flag = wr_lane & (awaddr == `OFS_FLAG);
  wire         wr_mm   = wr_lane & (awaddr == `OFS_MODE_MOD);
  wire         wr_data = wr_lane & (awaddr == `OFS_TX_DATA);
  wire         wr_map  = (awaddr == `OFS_COMMAND) | (awaddr == `OFS_MODE) |
                         (awaddr == `OFS_TX_CTRL) | (awaddr == `OFS_RX_CTRL) |
                         (awaddr == `OFS_FLAG) | (awaddr == `OFS_MODE_MOD) |
                         (awaddr == `OFS_TX_DATA) | (awaddr == `OFS_MAIN_ST) |
                         (awaddr == `OFS_LOOP_ST);
  wire [1:0]   cmd_code = wdata[`CMD_HI:`CMD_LO];
  wire         cmd_crc_rst = wr_cmd & (cmd_code == `CMD_RST_TXCRC);
  wire         cmd_eom_rst = wr_cmd & (cmd_code == `CMD_RST_EOM);
  wire         rd_go   = arvalid & ~rvalid_q;

  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = ~rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign txd     = txd_q;
  assign rts_n   = rts_n_q;

  // Transmit enable, with clear-to-send gating under auto-enables
  wire tx_en   = txc_q[`TXC_TX_EN] & ~(rxc_q[`RXC_AUTO_EN] & cts_s_q);
  wire loop_on = (lp_q != LP_OFF);
  wire eng_ok  = tx_en & ((lp_q == LP_OFF) | (lp_q == LP_SEND));

  // Next-character selection when the shifter runs empty
  wire ld       = (cnt_q == 5'h00);
  wire ld_data  = ld & eng_ok & tbuf_full_q;
  wire ld_end   = ld & eng_ok & ~tbuf_full_q & ~eom_q;
  wire ld_abort = ld_end & mm_q[`MM_ABORT_UR] & ~loop_on;
  wire ld_crc   = ld_end & ~ld_abort;
  wire ld_mark  = ld & ~ld_data & ~ld_end &
                  (~tx_en | (mm_q[`MM_MARK_IDLE] & ~loop_on));

  // Character length and parity
  wire [1:0] len_sel = txc_q[`TXC_LEN_HI:`TXC_LEN_LO];
  wire [3:0] len = (len_sel == 2'h0) ? `LEN_5 : (len_sel == 2'h1) ? `LEN_7 :
                   (len_sel == 2'h2) ? `LEN_6 : `LEN_8;
  wire [7:0] len_mask = 8'hff >> (`LEN_8 - len);
  wire [7:0] data_m   = tbuf_q & len_mask;
  wire       par_en   = mode_q[`MODE_PAR_EN];
  wire       par_bit  = ^data_m ^ ~mode_q[`MODE_PAR_EVEN];
  wire [15:0] par_word = par_en ? (16'h0001 << len) : 16'h0000;
  wire [15:0] data_word = {8'h00, data_m} | (par_bit ? par_word : 16'h0000);
  wire [4:0] data_cnt = {1'b0, len} + {4'h0, par_en};

  // Serial bit source; a disabled transmitter finishes CRC with flag bits
  wire stuffable = (kind_q == CH_DATA) | (kind_q == CH_CRC);
  wire cur_bit = ((kind_q == CH_CRC) & ~tx_en) ? flag_q[pos_q[2:0]]
                                               : shreg_q[0];
  wire stuff   = bit_tick & ~ld & stuffable & (ones_q == `ZI_RUN);
  wire out_bit = stuff ? 1'b0 : cur_bit;
  wire crc_fb  = crc_q[15] ^ cur_bit;
  wire crc_upd = bit_tick & ~ld & ~stuff & (kind_q == CH_DATA) &
                 txc_q[`TXC_CRC_EN] & ~txc_q[`TXC_POLY];

  // Receive-side pattern detection for loop operation
  wire [7:0] rx_nh   = {rxh_q[6:0], rx_s_q};
  wire       seven   = bit_tick & (rx_nh[6:0] == `SEVEN_ONES);
  wire       flag_rx = bit_tick & (rx_nh == flag_q);
  wire       send_end = ld & (lp_q == LP_SEND) & (kind_q == CH_FLAG) &
                        eom_q & ~tbuf_full_q & ~mm_q[`MM_GAOP];

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      crc_tx[i] = ~crc_q[15 - i];
    end
    if (ld_data) begin
      ld_word = data_word;
      ld_cnt  = data_cnt;
      ld_kind = CH_DATA;
    end else if (ld_crc) begin
      ld_word = crc_tx;
      ld_cnt  = `CRC_BITS;
      ld_kind = CH_CRC;
    end else if (ld_abort | ld_mark) begin
      ld_word = 16'h00ff;
      ld_cnt  = `CH_BITS;
      ld_kind = ld_abort ? CH_ABORT : CH_MARK;
    end else begin
      ld_word = {8'h00, flag_q};
      ld_cnt  = `CH_BITS;
      ld_kind = CH_FLAG;
    end
    st_main = 8'h00;
    st_main[`ST_TBE]  = ~tbuf_full_q;
    st_main[`ST_HUNT] = hunt_q;
    st_main[`ST_CTS]  = ~cts_s_q;
    st_main[`ST_EOM]  = eom_q;
    st_main[`ST_BRK]  = brk_q;
    st_loop = 8'h00;
    st_loop[`LST_ON_LOOP] = on_loop_q;
    st_loop[`LST_SENDING] = sending_q;
  end

  wire [7:0] rd_mux = (araddr == `OFS_COMMAND)  ? 8'h00  :
                      (araddr == `OFS_MODE)     ? mode_q :
                      (araddr == `OFS_TX_CTRL)  ? txc_q  :
                      (araddr == `OFS_RX_CTRL)  ? rxc_q  :
                      (araddr == `OFS_FLAG)     ? flag_q :
                      (araddr == `OFS_MODE_MOD) ? mm_q   :
                      (araddr == `OFS_TX_DATA)  ? tbuf_q :
                      (araddr == `OFS_MAIN_ST)  ? st_main :
                      (araddr == `OFS_LOOP_ST)  ? st_loop : 8'h00;
  wire rd_map = (araddr <= `OFS_LOOP_ST) & (araddr[1:0] == 2'h0);

  // Bus response channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OK;
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? `RESP_OK : `RESP_DECERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_map ? `RESP_OK : `RESP_DECERR;
        rdata_q  <= {24'h000000, rd_mux};
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Software registers and transmit buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `REG_RST;
      txc_q  <= `REG_RST;
      rxc_q  <= `REG_RST;
      flag_q <= `FLAG_RST;
      mm_q   <= `REG_RST;
      tbuf_q <= `REG_RST;
      tbuf_full_q <= 1'b0;
    end else begin
      if (wr_mode) mode_q <= wdata[7:0];
      if (wr_txc)  txc_q  <= wdata[7:0];
      if (wr_rxc)  rxc_q  <= wdata[7:0];
      if (wr_flag) flag_q <= wdata[7:0];
      if (wr_mm)   mm_q   <= wdata[7:0];
      if (wr_data) begin
        tbuf_q      <= wdata[7:0];
        tbuf_full_q <= 1'b1;
      end else if (ld_data) begin
        tbuf_full_q <= 1'b0;
      end
    end
  end

  // Pin synchronisers and request-to-send
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_m_q  <= 1'b1;
      rx_s_q  <= 1'b1;
      cts_m_q <= 1'b1;
      cts_s_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      rx_m_q  <= rxd;
      rx_s_q  <= rx_m_q;
      cts_m_q <= cts_n;
      cts_s_q <= cts_m_q;
      rts_n_q <= ~txc_q[`TXC_RTS];
    end
  end

  // Shifter, zero inserter and CRC generator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q <= 16'h0000;
      cnt_q   <= 5'h00;
      pos_q   <= 4'h0;
      kind_q  <= CH_MARK;
      ones_q  <= 3'h0;
      zi_q    <= 5'h1f;
      crc_q   <= 16'h0000;
      eom_q   <= 1'b1;
    end else begin
      if (ld) begin
        shreg_q <= ld_word;
        cnt_q   <= ld_cnt;
        kind_q  <= ld_kind;
        pos_q   <= 4'h0;
      end else if (bit_tick) begin
        zi_q <= {zi_q[`ZI_DEPTH-2:0], out_bit};
        if (stuff) begin
          ones_q <= 3'h0;
        end else begin
          shreg_q <= {1'b0, shreg_q[15:1]};
          cnt_q   <= cnt_q - 5'h01;
          pos_q   <= pos_q + 4'h1;
          ones_q  <= (cur_bit & stuffable) ? ones_q + 3'h1 : 3'h0;
        end
      end
      if (cmd_crc_rst) begin
        crc_q <= mm_q[`MM_PRESET] ? 16'hffff : 16'h0000;
      end else if (crc_upd) begin
        crc_q <= {crc_q[14:0], 1'b0} ^ (crc_fb ? `CRC_POLY : 16'h0000);
      end
      if (ld_end) begin
        eom_q <= 1'b1;
      end else if (cmd_eom_rst) begin
        eom_q <= 1'b0;
      end
    end
  end

  // Loop-station state and receive status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_q      <= LP_OFF;
      rxh_q     <= 8'h00;
      rx_dly_q  <= 1'b1;
      txd_q     <= 1'b1;
      brk_q     <= 1'b0;
      hunt_q    <= 1'b1;
      on_loop_q <= 1'b0;
      sending_q <= 1'b0;
    end else begin
      if (bit_tick) begin
        rxh_q    <= rx_nh;
        rx_dly_q <= rx_s_q;
      end
      if (seven) begin
        brk_q <= 1'b1;
      end else if (bit_tick & ~rx_s_q) begin
        brk_q <= 1'b0;
      end
      if (seven) begin
        hunt_q <= 1'b1;
      end else if (flag_rx) begin
        hunt_q <= 1'b0;
      end
      case (lp_q)
        LP_OFF:  txd_q <= zi_q[`ZI_DEPTH-1];
        LP_SEND: txd_q <= zi_q[`ZI_DEPTH-1];
        LP_IDLE: txd_q <= rx_s_q;
        default: txd_q <= rx_dly_q;
      endcase
      case (lp_q)
        LP_OFF: begin
          if (mm_q[`MM_LOOP]) lp_q <= LP_IDLE;
        end
        LP_IDLE: begin
          if (!mm_q[`MM_LOOP]) begin
            lp_q <= LP_OFF;
          end else if (mm_q[`MM_GAOP] & seven) begin
            lp_q      <= LP_HUNT;
            on_loop_q <= 1'b1;
          end
        end
        LP_HUNT, LP_ON: begin
          if (!mm_q[`MM_LOOP] & (seven | hunt_q)) begin
            lp_q      <= LP_OFF;
            on_loop_q <= 1'b0;
          end else if (lp_q == LP_HUNT & flag_rx) begin
            lp_q <= LP_ON;
          end else if (lp_q == LP_ON & mm_q[`MM_GAOP] & seven) begin
            lp_q      <= LP_SEND;
            sending_q <= 1'b1;
          end
        end
        LP_SEND: begin
          if (send_end) begin
            lp_q      <= LP_ON;
            sending_q <= 1'b0;
          end
        end
        default: lp_q <= LP_OFF;
      endcase
    end
  end

  chk_rts_follows_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    txc_q[`TXC_RTS] ##1 txc_q[`TXC_RTS] |-> !rts_n)
    else $error("rts_n does not invert the control bit");
  chk_eom_set_end: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_end |=> eom_q && (kind_q == CH_CRC || kind_q == CH_ABORT))
    else $error("end-of-message latch not set on CRC or abort");
  chk_crc_hold_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !txc_q[`TXC_CRC_EN] && !cmd_crc_rst |=> $stable(crc_q))
    else $error("CRC changed while disabled");
  chk_crc_preset_val: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_crc_rst |=> crc_q == ($past(mm_q[`MM_PRESET]) ? 16'hffff : 16'h0000))
    else $error("CRC preset value wrong");
  chk_parity_count: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_data |=> cnt_q == {1'b0, $past(len)} + {4'h0, $past(par_en)})
    else $error("character bit count wrong");
  chk_underrun_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    ld & eng_ok & !tbuf_full_q & eom_q & !mm_q[`MM_MARK_IDLE] |=> kind_q == CH_FLAG)
    else $error("underrun with latch set did not send flag");
  chk_crc_sixteen: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_crc |=> cnt_q == `CRC_BITS)
    else $error("CRC not sixteen bit times");
  chk_loop_no_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_end && loop_on |=> kind_q == CH_CRC)
    else $error("abort sent in loop mode");
  chk_go_on_loop: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_q == LP_IDLE && mm_q[`MM_LOOP] && mm_q[`MM_GAOP] && seven
    |=> on_loop_q && hunt_q && brk_q && lp_q == LP_HUNT)
    else $error("on-loop entry incomplete");
  chk_auto_cts_off: assert property (@(posedge aclk) disable iff (!aresetn)
    rxc_q[`RXC_AUTO_EN] && cts_s_q |-> !tx_en)
    else $error("transmitter enabled with clear-to-send high");
  chk_stuff_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    stuff |=> zi_q[0] == 1'b0 && ones_q == 3'h0)
    else $error("inserted bit not zero");
endmodule : sdlc_transmit_and_loop

// ### sdlc_tx_pkg.sv
// Purpose: Shared types of the framer
// Assumes: Used with sdlc_tx_regs.svh
// Notes:   Enums carry no explicit codes
package sdlc_tx_pkg;
  typedef enum logic [2:0] {CH_DATA, CH_FLAG, CH_CRC, CH_ABORT, CH_MARK}
    char_kind_e;
  typedef enum logic [2:0] {LP_OFF, LP_IDLE, LP_HUNT, LP_ON, LP_SEND}
    loop_state_e;
endpackage : sdlc_tx_pkg

// ### sdlc_tx_regs.svh
// Purpose: Register offsets, field positions and constants of the framer
// Assumes: Byte addresses on an AXI4-Lite bus, one 32-bit word per register
// Notes:   Contract
`ifndef SDLC_TX_REGS_SVH
`define SDLC_TX_REGS_SVH
`define OFS_COMMAND   8'h00
`define OFS_MODE      8'h04
`define OFS_TX_CTRL   8'h08
`define OFS_RX_CTRL   8'h0c
`define OFS_FLAG      8'h10
`define OFS_MODE_MOD  8'h14
`define OFS_TX_DATA   8'h18
`define OFS_MAIN_ST   8'h1c
`define OFS_LOOP_ST   8'h20
`define CMD_HI        7
`define CMD_LO        6
`define CMD_RST_TXCRC 2'h2
`define CMD_RST_EOM   2'h3
`define MODE_PAR_EN   6
`define MODE_PAR_EVEN 1
`define TXC_CRC_EN    0
`define TXC_RTS       1
`define TXC_POLY      2
`define TXC_TX_EN     3
`define TXC_LEN_HI    6
`define TXC_LEN_LO    5
`define RXC_AUTO_EN   5
`define MM_LOOP       1
`define MM_ABORT_UR   2
`define MM_MARK_IDLE  3
`define MM_GAOP       4
`define MM_PRESET     7
`define ST_TBE        0
`define ST_HUNT       4
`define ST_CTS        5
`define ST_EOM        6
`define ST_BRK        7
`define LST_ON_LOOP   1
`define LST_SENDING   4
`define FLAG_RST      8'h7e
`define REG_RST       8'h00
`define CH_BITS       5'h08
`define CRC_BITS      5'h10
`define CRC_POLY      16'h1021
`define ZI_RUN        3'h5
`define ZI_DEPTH      5
`define SEVEN_ONES    7'h7f
`define LEN_5         4'h5
`define LEN_6         4'h6
`define LEN_7         4'h7
`define LEN_8         4'h8
`define RESP_OK       2'h0
`define RESP_DECERR   2'h3
`endif

// ### testbench.sv
// Purpose: Register-level tests of the transmit framer and loop station
// Assumes: AXI4-Lite master tasks; far station model drives rxd and bit_tick
// Notes:   Serial checks use the longest run of ones seen on txd
`timescale 1ns/1ps
`include "sdlc_tx_regs.svh"
module testbench;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        bit_tick;
  logic        rxd;
  logic        cts_n;
  logic        txd;
  logic        rts_n;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          err_total;
  int          checks;
  int          cyc;

  sdlc_transmit_and_loop dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .bit_tick(bit_tick),
    .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n)
  );

  line_station peer_u (
    .aclk(aclk), .aresetn(aresetn), .txd(txd), .bit_tick(bit_tick),
    .rxd(rxd)
  );

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  task chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_data

  task chk_pin(input string n, input logic e, input logic g);
    chk_data(n, {31'h0, e}, {31'h0, g});
  endtask : chk_pin

  // Handshakes are looked at mid-cycle, where the slave's outputs settle
  task wr(input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s = 4'hf);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge aclk);
    while (!(awready && wready)) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge aclk);
    while (bvalid !== 1'b1) @(negedge aclk);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (arready !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1) @(negedge aclk);
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd_reg

  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
            input string n);
    int i;
    i = 0;
    rd_reg(a);
    while (((rd & m) !== e) && i < 200) begin
      rd_reg(a);
      i++;
    end
    chk_data(n, e, rd & m);
  endtask : poll

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    cts_n = 1'b0;
    aresetn = 1'b0;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`OFS_FLAG);
    chk_data("flag reset", 32'h7e, rd);
    wr(`OFS_FLAG, 32'h55, 4'h0);
    rd_reg(`OFS_FLAG);
    chk_data("strobe off", 32'h7e, rd);
    rd_reg(`OFS_MAIN_ST);
    chk_data("status reset", 32'h51, rd & 32'h51);
    wr(8'h24, 32'h1);
    chk_data("write unmapped", 32'h3, {30'h0, rs});
    rd_reg(8'h24);
    chk_data("read unmapped", 32'h3, {30'h0, rs});
    $display("test reset_map done");
    wr(`OFS_TX_CTRL, 32'h02);
    repeat (2) @(posedge aclk);
    chk_pin("rts_n set", 1'b0, rts_n);
    wr(`OFS_TX_CTRL, 32'h00);
    repeat (2) @(posedge aclk);
    chk_pin("rts_n clear", 1'b1, rts_n);
    cts_n <= 1'b1;
    poll(`OFS_MAIN_ST, 32'h20, 32'h00, "cts status");
    cts_n <= 1'b0;
    poll(`OFS_MAIN_ST, 32'h20, 32'h20, "cts status");
    $display("test modem done");
    // Framing setup in the documented order, then preset the CRC
    wr(`OFS_MODE, 32'h00);
    wr(`OFS_MODE_MOD, 32'h80);
    wr(`OFS_FLAG, 32'h7e);
    wr(`OFS_RX_CTRL, 32'h00);
    wr(`OFS_TX_CTRL, 32'h69);
    wr(`OFS_COMMAND, 32'h80);
    peer_u.wait_ticks(30);
    peer_u.clr_run();
    peer_u.wait_ticks(40);
    chk_data("idle run", 32'd6, 32'(peer_u.max_run));
    // All-ones data with CRC: inserted zeros keep runs at the flag's six
    wr(`OFS_TX_DATA, 32'hff);
    wr(`OFS_COMMAND, 32'hc0);
    rd_reg(`OFS_MAIN_ST);
    chk_data("eom cleared", 32'h00, rd & 32'h40);
    poll(`OFS_MAIN_ST, 32'h01, 32'h01, "buffer empty");
    wr(`OFS_TX_DATA, 32'hff);
    poll(`OFS_MAIN_ST, 32'h40, 32'h40, "eom set by crc");
    peer_u.wait_ticks(40);
    chk_data("crc frame run", 32'd6, 32'(peer_u.max_run));
    $display("test crc_frame done");
    wr(`OFS_MODE_MOD, 32'h84);
    wr(`OFS_TX_DATA, 32'h00);
    wr(`OFS_COMMAND, 32'hc0);
    poll(`OFS_MAIN_ST, 32'h40, 32'h40, "eom set by abort");
    peer_u.wait_ticks(40);
    chk_data("abort run", 32'd8, 32'(peer_u.max_run));
    $display("test abort done");
    wr(`OFS_MODE_MOD, 32'h80);
    wr(`OFS_RX_CTRL, 32'h20);
    cts_n <= 1'b1;
    peer_u.wait_ticks(20);
    wr(`OFS_TX_DATA, 32'h55);
    peer_u.wait_ticks(40);
    rd_reg(`OFS_MAIN_ST);
    chk_data("held by cts", 32'h00, rd & 32'h01);
    cts_n <= 1'b0;
    poll(`OFS_MAIN_ST, 32'h01, 32'h01, "sent after cts");
    wr(`OFS_RX_CTRL, 32'h00);
    $display("test auto_enable done");
    // Loop station: go on loop, poll, send, stop, leave
    wr(`OFS_MODE_MOD, 32'h86);
    wr(`OFS_MODE_MOD, 32'h96);
    peer_u.send(8'hff);
    poll(`OFS_LOOP_ST, 32'h02, 32'h02, "on loop");
    chk_data("not sending", 32'h00, rd & 32'h10);
    peer_u.send(8'h7e);
    peer_u.send(8'hfe);
    poll(`OFS_LOOP_ST, 32'h10, 32'h10, "loop sending");
    wr(`OFS_MODE_MOD, 32'h86);
    poll(`OFS_LOOP_ST, 32'h10, 32'h00, "loop send end");
    wr(`OFS_MODE_MOD, 32'h80);
    peer_u.send(8'hff);
    poll(`OFS_LOOP_ST, 32'h02, 32'h00, "off loop");
    $display("test loop done");
    report_and_stop();
  end
endmodule : testbench
